// file: core/mil_irq.v
// interrupt logic of an 8-bit controller core with an AHB-Lite register slave
// Operation
// (RQ1) ten sources: pin, timer0, port, seven peripherals
// (RQ2) global enable bit 7, cleared by resets
// (RQ3) individual enable clear blocks its source
// (RQ4) return instruction sets global enable again
// (RQ5) entry clears global enable, pushes, vectors 0004h
// (RQ6) flags set regardless of any enable
// (RQ7) latency three instruction cycles after Q1 sample
// (RQ8) enable clear: next cycle NOP, requests stay
// (RQ9) peripheral flags and enables share bit layout
// (RQ10) pin edge chosen by option bit 6
// (RQ11) enabled pin interrupt wakes core from sleep
// (RQ12) timer0 rollover sets flag bit 2, enable 5
// (RQ13) port pins 7:4 change sets flag bit 0
// (RQ14) change during Q2 port read is lost
// (RQ15) pin flag sampled for request every Q1
// (RQ16) only return address saved on entry
// (RQ17) software clears flag before re-enabling interrupts
// (RQ18) control register mirrored, port flag survives resets; only other_reset keeps it, hresetn clears it
// (RQ19) core request: global and grouped enable gating
`timescale 1ns/1ps
`default_nettype none
`include "mil_map.vh"

module mil_irq
(
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   input  wire        other_reset,
   input  wire        ext_irq_pin,
   input  wire [3:0]  port_b_pins,
   input  wire        port_read,
   input  wire        timer0_overflow,
   input  wire        comparator_event,
   input  wire        serial_tx_event,
   input  wire        serial_rx_event,
   input  wire        capture_compare_event,
   input  wire        timer1_overflow,
   input  wire        timer2_match,
   input  wire        eeprom_done,
   input  wire        global_clear_exec,
   input  wire        return_from_interrupt,
   input  wire        core_sleep,
   input  wire [12:0] core_pc,
   output reg  [1:0]  q_phase,
   output reg         irq_request,
   output reg         pc_load,
   output reg  [12:0] pc_value,
   output reg         stack_push,
   output reg  [12:0] push_addr,
   output reg         nop_insert,
   output reg         wake_request,
   output reg         irq
);

// ----------------------------------------------------------------------
// address decode
// ----------------------------------------------------------------------
function [2:0] reg_select;
   input [`MIL_IDX_W-1:0] idx;
   begin
      case (idx)
         `MIL_IDX_CTL_0, `MIL_IDX_CTL_1,
         `MIL_IDX_CTL_2, `MIL_IDX_CTL_3:       reg_select = `MIL_SEL_CTL; // RQ18
         `MIL_IDX_PIRQ:                       reg_select = `MIL_SEL_PIRQ;
         `MIL_IDX_PIEN:                       reg_select = `MIL_SEL_PIEN;
         `MIL_IDX_OPTION_0, `MIL_IDX_OPTION_1: reg_select = `MIL_SEL_OPTION;
         `MIL_IDX_STATUS:                     reg_select = `MIL_SEL_STATUS;
         `MIL_IDX_MASK:                       reg_select = `MIL_SEL_MASK;
         default:                             reg_select = `MIL_SEL_NONE;
      endcase
   end
endfunction

// ----------------------------------------------------------------------
// declarations
// ----------------------------------------------------------------------
reg  [7:0]  interrupt_control;
reg  [7:0]  peripheral_irq_flags;
reg  [7:0]  peripheral_irq_enables;
reg  [7:0]  option_reg;
reg  [2:0]  irq_status;
reg  [2:0]  irq_mask;
reg  [2:0]  dp_sel;
reg         dp_write;
reg         rd_pend;
reg         ext_s1;
reg         ext_s2;
reg         ext_prev;
reg  [3:0]  port_s1;
reg  [3:0]  port_s2;
reg  [3:0]  port_prev;
reg         busy;
reg  [1:0]  lat_count;
reg  [1:0]  hold_state;
reg  [7:0]  next_control;
reg  [7:0]  next_pirq;
reg  [7:0]  next_pien;
reg  [7:0]  next_option;
reg  [2:0]  next_status;
reg  [2:0]  next_mask;
reg  [1:0]  next_hold;
reg  [31:0] read_value;
wire        take;
wire        wr_en;
wire        q1;
wire        ext_edge;
wire        port_change;
wire        core_pairs;
wire        periph_pairs;
wire        req;
wire        wake_cond;
wire        accept;
wire        vector_fire;
wire        glb_drop;

localparam [1:0] HOLD_IDLE  = 2'b00;
localparam [1:0] HOLD_ARMED = 2'b01;
localparam [1:0] HOLD_NOP   = 2'b10;

// ----------------------------------------------------------------------
// bus handshake
// ----------------------------------------------------------------------
assign take  = hsel & htrans[1] & hready;
assign wr_en = dp_write;

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      dp_sel    <= `MIL_SEL_NONE;
      dp_write  <= 1'b0;
      rd_pend   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
   end
   else
   begin
      dp_write <= take & hwrite;
      rd_pend  <= take & ~hwrite;
      if (take)
         dp_sel <= reg_select(haddr[`MIL_IDX_W+1:2]);
      // one wait state on reads so data reflect any write just landed
      if (take && !hwrite)
         hreadyout <= 1'b0;
      else
         hreadyout <= 1'b1;
      if (rd_pend)
         hrdata <= read_value;
   end
end

always @*
begin
   read_value = 32'h00000000;
   case (dp_sel)
      `MIL_SEL_CTL:    read_value[7:0] = interrupt_control;
      `MIL_SEL_PIRQ:   read_value[7:0] = peripheral_irq_flags;
      `MIL_SEL_PIEN:   read_value[7:0] = peripheral_irq_enables;
      `MIL_SEL_OPTION: read_value[7:0] = option_reg;
      `MIL_SEL_STATUS: read_value[2:0] = irq_status;
      `MIL_SEL_MASK:   read_value[2:0] = irq_mask;
      default:         read_value = 32'h00000000;
   endcase
end

// ----------------------------------------------------------------------
// pin synchronisers and event detection
// ----------------------------------------------------------------------
always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      ext_s1    <= 1'b0;
      ext_s2    <= 1'b0;
      ext_prev  <= 1'b0;
      port_s1   <= 4'h0;
      port_s2   <= 4'h0;
      port_prev <= 4'h0;
   end
   else
   begin
      ext_s1    <= ext_irq_pin;
      ext_s2    <= ext_s1;
      ext_prev  <= ext_s2;
      port_s1   <= port_b_pins;
      port_s2   <= port_s1;
      port_prev <= port_s2;
   end
end

assign ext_edge = option_reg[`MIL_EDGE_SEL] ? (ext_s2 & ~ext_prev)
                                            : (~ext_s2 & ext_prev); // RQ10
assign port_change = (port_s2 != port_prev)
                   & ~(port_read & (q_phase == `MIL_Q2)); // RQ13 RQ14

// ----------------------------------------------------------------------
// request, wake and acceptance
// ----------------------------------------------------------------------
assign core_pairs = |(interrupt_control[`MIL_T0_EN:`MIL_PORT_EN]
                    & interrupt_control[`MIL_T0_FLG:`MIL_PORT_FLG]); // RQ3
assign periph_pairs = |(peripheral_irq_flags & peripheral_irq_enables); // RQ9
assign req = interrupt_control[`MIL_GLB_EN]
           & (core_pairs | (interrupt_control[`MIL_GRP_EN] & periph_pairs)); // RQ2 RQ19
assign wake_cond = core_pairs | periph_pairs; // RQ11
assign q1 = (q_phase == `MIL_Q1);
// request is looked at only on Q1, so a late pin edge waits one more cycle
assign accept = q1 & ~busy & req & ~core_sleep
              & (hold_state == HOLD_IDLE); // RQ15 RQ8
assign vector_fire = q1 & busy & (lat_count == `MIL_LAT_LAST); // RQ7
assign glb_drop = interrupt_control[`MIL_GLB_EN] & ~next_control[`MIL_GLB_EN]
                & ~accept & ~other_reset;

// ----------------------------------------------------------------------
// interrupt control register
// ----------------------------------------------------------------------
always @*
begin
   next_control = interrupt_control;
   if (wr_en && dp_sel == `MIL_SEL_CTL)
      next_control = hwdata[7:0];
   if (global_clear_exec)
      next_control[`MIL_GLB_EN] = 1'b0;
   if (return_from_interrupt)
      next_control[`MIL_GLB_EN] = 1'b1; // RQ4
   if (accept)
      next_control[`MIL_GLB_EN] = 1'b0; // RQ5
   if (timer0_overflow)
      next_control[`MIL_T0_FLG] = 1'b1; // RQ12 RQ6
   if (ext_edge)
      next_control[`MIL_PIN_FLG] = 1'b1; // RQ10 RQ6
   if (port_change)
      next_control[`MIL_PORT_FLG] = 1'b1; // RQ13 RQ6
   if (other_reset)
      next_control = `MIL_CTL_RST | (next_control & `MIL_PORT_KEEP); // RQ18 RQ2
end

// ----------------------------------------------------------------------
// peripheral flags, enables and option
// ----------------------------------------------------------------------
always @*
begin
   next_pirq = peripheral_irq_flags;
   if (wr_en && dp_sel == `MIL_SEL_PIRQ)
      next_pirq = hwdata[7:0] & `MIL_PER_IMPL;
   if (eeprom_done)
      next_pirq[`MIL_P_EE] = 1'b1; // RQ1 RQ6
   if (comparator_event)
      next_pirq[`MIL_P_CM] = 1'b1;
   if (serial_rx_event)
      next_pirq[`MIL_P_RX] = 1'b1;
   if (serial_tx_event)
      next_pirq[`MIL_P_TX] = 1'b1;
   if (capture_compare_event)
      next_pirq[`MIL_P_CCP] = 1'b1;
   if (timer2_match)
      next_pirq[`MIL_P_TMR2] = 1'b1;
   if (timer1_overflow)
      next_pirq[`MIL_P_TMR1] = 1'b1;
   if (other_reset)
      next_pirq = `MIL_PIRQ_RST;
end

always @*
begin
   next_pien = peripheral_irq_enables;
   next_option = option_reg;
   if (wr_en && dp_sel == `MIL_SEL_PIEN)
      next_pien = hwdata[7:0] & `MIL_PER_IMPL; // RQ9
   if (wr_en && dp_sel == `MIL_SEL_OPTION)
      next_option = hwdata[7:0];
   if (other_reset)
   begin
      next_pien = `MIL_PIEN_RST;
      next_option = `MIL_OPTION_RST;
   end
end

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      interrupt_control      <= `MIL_CTL_RST; // RQ2
      peripheral_irq_flags   <= `MIL_PIRQ_RST;
      peripheral_irq_enables <= `MIL_PIEN_RST;
      option_reg             <= `MIL_OPTION_RST;
   end
   else
   begin
      interrupt_control      <= next_control;
      peripheral_irq_flags   <= next_pirq;
      peripheral_irq_enables <= next_pien;
      option_reg             <= next_option;
   end
end

// ----------------------------------------------------------------------
// instruction cycle phase and vectoring
// ----------------------------------------------------------------------
always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      q_phase    <= `MIL_Q1;
      busy       <= 1'b0;
      lat_count  <= 2'h0;
      pc_load    <= 1'b0;
      pc_value   <= 13'h0000;
      stack_push <= 1'b0;
      push_addr  <= 13'h0000;
   end
   else
   begin
      q_phase    <= q_phase + 2'h1;
      pc_load    <= 1'b0;
      stack_push <= 1'b0;
      if (other_reset)
      begin
         busy      <= 1'b0;
         lat_count <= 2'h0;
      end
      else if (accept)
      begin
         busy      <= 1'b1;
         lat_count <= `MIL_LAT_TCY; // RQ7
      end
      else if (vector_fire)
      begin
         busy       <= 1'b0;
         lat_count  <= 2'h0;
         pc_load    <= 1'b1; // RQ5
         pc_value   <= `MIL_VECTOR;
         stack_push <= 1'b1; // RQ16
         push_addr  <= core_pc;
      end
      else if (q1 && busy)
         lat_count <= lat_count - 2'h1;
   end
end

// ----------------------------------------------------------------------
// nop slot after an instruction clears the global enable
// ----------------------------------------------------------------------
always @*
begin
   next_hold = hold_state;
   case (hold_state)
      HOLD_IDLE:
         if (glb_drop)
            next_hold = HOLD_ARMED;
      HOLD_ARMED:
         if (q1)
            next_hold = HOLD_NOP; // RQ8
      HOLD_NOP:
         if (q1)
            next_hold = glb_drop ? HOLD_ARMED : HOLD_IDLE;
      default:
         next_hold = HOLD_IDLE;
   endcase
   if (other_reset)
      next_hold = HOLD_IDLE;
end

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      hold_state   <= HOLD_IDLE;
      nop_insert   <= 1'b0;
      irq_request  <= 1'b0;
      wake_request <= 1'b0;
   end
   else
   begin
      hold_state   <= next_hold;
      nop_insert   <= (next_hold == HOLD_NOP); // RQ8
      irq_request  <= req; // RQ19
      wake_request <= core_sleep & wake_cond; // RQ11
   end
end

// ----------------------------------------------------------------------
// event status, mask and interrupt output
// ----------------------------------------------------------------------
always @*
begin
   next_status = irq_status;
   next_mask = irq_mask;
   if (rd_pend && dp_sel == `MIL_SEL_STATUS)
      next_status = `MIL_STAT_RST;
   if (wr_en && dp_sel == `MIL_SEL_MASK)
      next_mask = hwdata[2:0];
   if (vector_fire)
      next_status[`MIL_ST_ENTRY] = 1'b1;
   if (core_sleep && wake_cond && !wake_request)
      next_status[`MIL_ST_WAKE] = 1'b1;
   if (return_from_interrupt)
      next_status[`MIL_ST_RETURN] = 1'b1;
end

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      irq_status <= `MIL_STAT_RST;
      irq_mask   <= `MIL_MASK_RST;
      irq        <= 1'b0;
   end
   else
   begin
      irq_status <= next_status;
      irq_mask   <= next_mask;
      irq        <= |(next_status & next_mask);
   end
end

endmodule
`default_nettype wire

// file: core/mil_map.vh
// register map, field positions, reset values and timing counts of the interrupt logic
`ifndef MIL_MAP_VH
`define MIL_MAP_VH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define MIL_IDX_W          9
`define MIL_IDX_CTL_0      9'h00B
`define MIL_IDX_CTL_1      9'h08B
`define MIL_IDX_CTL_2      9'h10B
`define MIL_IDX_CTL_3      9'h18B
`define MIL_IDX_PIRQ       9'h00C
`define MIL_IDX_PIEN       9'h08C
`define MIL_IDX_OPTION_0   9'h081
`define MIL_IDX_OPTION_1   9'h181
`define MIL_IDX_STATUS     9'h040
`define MIL_IDX_MASK       9'h041

// ----------------------------------------------------------------------
// decoded register selects
// ----------------------------------------------------------------------
`define MIL_SEL_NONE       3'h0
`define MIL_SEL_CTL        3'h1
`define MIL_SEL_PIRQ       3'h2
`define MIL_SEL_PIEN       3'h3
`define MIL_SEL_OPTION     3'h4
`define MIL_SEL_STATUS     3'h5
`define MIL_SEL_MASK       3'h6

// ----------------------------------------------------------------------
// interrupt control fields
// ----------------------------------------------------------------------
`define MIL_GLB_EN         7
`define MIL_GRP_EN         6
`define MIL_T0_EN          5
`define MIL_PIN_EN         4
`define MIL_PORT_EN        3
`define MIL_T0_FLG         2
`define MIL_PIN_FLG        1
`define MIL_PORT_FLG       0
`define MIL_PORT_KEEP      8'h01
`define MIL_EDGE_SEL       6

// ----------------------------------------------------------------------
// peripheral flag / enable fields (same layout)
// ----------------------------------------------------------------------
`define MIL_P_EE           7
`define MIL_P_CM           6
`define MIL_P_RX           5
`define MIL_P_TX           4
`define MIL_P_CCP          2
`define MIL_P_TMR2         1
`define MIL_P_TMR1         0
`define MIL_PER_IMPL       8'hF7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MIL_CTL_RST        8'h00
`define MIL_PIRQ_RST       8'h00
`define MIL_PIEN_RST       8'h00
`define MIL_OPTION_RST     8'hFF
`define MIL_STAT_RST       3'h0
`define MIL_MASK_RST       3'h0

// ----------------------------------------------------------------------
// event status bits
// ----------------------------------------------------------------------
`define MIL_ST_ENTRY       0
`define MIL_ST_WAKE        1
`define MIL_ST_RETURN      2

// ----------------------------------------------------------------------
// core timing and vector
// ----------------------------------------------------------------------
`define MIL_Q1             2'h0
`define MIL_Q2             2'h1
`define MIL_LAT_TCY        2'h3
`define MIL_LAT_LAST       2'h1
`define MIL_VECTOR         13'h0004

`endif

// file: testbench/mil_core_model.sv
// behavioural core sequencer: program counter and hardware stack depth
`timescale 1ns/1ps
`default_nettype none
module mil_core_model
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [1:0]  q_phase,
   input  wire logic        pc_load,
   input  wire logic [12:0] pc_value,
   input  wire logic        stack_push,
   output var  logic [12:0] core_pc,
   output var  logic [3:0]  depth
);
   // ----------------------------------------
   // fetch advance and vector load
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         core_pc <= 13'h0100;
         depth <= 4'h0;
      end
      else if (pc_load)
      begin
         core_pc <= pc_value;
         depth <= depth + {3'h0, stack_push};
      end
      else if (q_phase == 2'h3)
         core_pc <= core_pc + 13'h0001;
   end
endmodule
`default_nettype wire

// file: testbench/mil_irq_props.sv
// concurrent checks on the ports of the interrupt logic
`timescale 1ns/1ps
`default_nettype none
module mil_irq_props
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        global_clear_exec,
   input wire logic        core_sleep,
   input wire logic [1:0]  q_phase,
   input wire logic        pc_load,
   input wire logic [12:0] pc_value,
   input wire logic        stack_push,
   input wire logic        nop_insert,
   input wire logic        wake_request
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd_req; hsel && htrans[1] && hready && !hwrite; endsequence
   sequence s_wr_req; hsel && htrans[1] && hready && hwrite; endsequence
   sequence s_wait_one; !hreadyout ##1 hreadyout; endsequence
   sequence s_nop_slot; nop_insert [*4] ##1 !nop_insert; endsequence
   property p_rd_wait; s_rd_req |=> s_wait_one; endproperty
   property p_wr_zero; s_wr_req |=> hreadyout; endproperty
   property p_okay; hresp == 1'b0; endproperty
   property p_vec_addr; pc_load |-> pc_value == 13'h0004; endproperty
   property p_push_pair; pc_load == stack_push; endproperty
   property p_load_once; pc_load |=> !pc_load [*8]; endproperty
   property p_nop_len; $rose(nop_insert) |-> s_nop_slot; endproperty
   property p_nop_follow; global_clear_exec |-> ##[1:8] nop_insert; endproperty
   property p_phase; q_phase == 2'h1 |=> q_phase == 2'h2; endproperty
   property p_wake; !core_sleep |=> !wake_request; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   a_wr_zero: assert property (p_wr_zero) else $error("write not zero wait");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");
   a_push_pair: assert property (p_push_pair) else $error("push without load");
   a_load_once: assert property (p_load_once) else $error("vector repeated");
   a_nop_len: assert property (p_nop_len) else $error("nop slot length wrong");
   a_nop_follow: assert property (p_nop_follow) else $error("nop slot missing");
   a_phase: assert property (p_phase) else $error("phase sequence wrong");
   a_wake: assert property (p_wake) else $error("wake while awake");
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench of the interrupt logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
   localparam logic [31:0] A_CTL = 32'h2C, A_CTL1 = 32'h22C, A_CTL3 = 32'h62C;
   localparam logic [31:0] A_FLG = 32'h30, A_EN = 32'h230, A_OPT = 32'h204;
   localparam logic [31:0] A_STS = 32'h100, A_MSK = 32'h104, A_BAD = 32'h140;
   logic             hclk = 1'b0;
   logic             hresetn = 1'b0;
   logic             hsel = 1'b0;
   logic [31:0]      haddr = 32'h0;
   logic [1:0]       htrans = 2'h0;
   logic             hwrite = 1'b0;
   logic [31:0]      hwdata = 32'h0;
   logic [7:0]       ev = 8'h00;
   logic             other_reset = 1'b0;
   logic             pin = 1'b0;
   logic [3:0]       port_b = 4'h0;
   logic             drop_global = 1'b0;
   logic             rfi = 1'b0;
   logic             sleep = 1'b0;
   logic             prd = 1'b0;
   wire logic        hreadyout, hresp, irq_request, pc_load, stack_push;
   wire logic        nop_insert, wake_request, irq;
   wire logic [31:0] hrdata;
   wire logic [1:0]  q_phase;
   wire logic [12:0] pc_value, push_addr, core_pc;
   wire logic [3:0]  depth;
   int               n_mismatch = 0;
   int               check_count = 0;
   int               n_vec = 0;
   always #2.5 hclk = ~hclk;
   always @(posedge hclk) if (pc_load === 1'b1) n_vec <= n_vec + 1;
   mil_irq i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .other_reset(other_reset),
      .ext_irq_pin(pin), .port_b_pins(port_b), .port_read(prd), .timer0_overflow(ev[3]),
      .comparator_event(ev[6]), .serial_tx_event(ev[4]), .serial_rx_event(ev[5]),
      .capture_compare_event(ev[2]), .timer1_overflow(ev[0]), .timer2_match(ev[1]),
      .eeprom_done(ev[7]), .global_clear_exec(drop_global), .return_from_interrupt(rfi),
      .core_sleep(sleep), .core_pc(core_pc), .q_phase(q_phase), .irq_request(irq_request),
      .pc_load(pc_load), .pc_value(pc_value), .stack_push(stack_push), .push_addr(push_addr),
      .nop_insert(nop_insert), .wake_request(wake_request), .irq(irq));
   mil_core_model i_core (.hclk(hclk), .hresetn(hresetn), .q_phase(q_phase),
      .pc_load(pc_load), .pc_value(pc_value), .stack_push(stack_push), .core_pc(core_pc),
      .depth(depth));
   // ----------------------------------------
   // bus cycles and helpers
   // ----------------------------------------
   task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string nm, input logic [31:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      `CHK(nm, {24'h0, e}, q)
   endtask
   task automatic pulse_ev(input logic [7:0] m);
      @(posedge hclk);
      ev <= m;
      @(posedge hclk);
      ev <= 8'h00;
   endtask
   task automatic set_pin(input logic v);
      @(posedge hclk);
      pin <= v;
      repeat (8) @(posedge hclk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_values;
      rd_chk("control", A_CTL, 8'h00);
      rd_chk("flags", A_FLG, 8'h00);
      rd_chk("enables", A_EN, 8'h00);
      rd_chk("option", A_OPT, 8'hFF);
      rd_chk("status", A_STS, 8'h00);
      rd_chk("mask", A_MSK, 8'h00);
      rd_chk("unmapped", A_BAD, 8'h00);
   endtask
   task automatic t_flags;
      pulse_ev(8'hFF);
      rd_chk("all flags", A_FLG, 8'hF7);
      rd_chk("timer0 flag", A_CTL, 8'h04);
      wr(A_FLG, 8'h00);
      wr(A_CTL3, 8'h04);
      rd_chk("mirror", A_CTL1, 8'h04);
      wr(A_CTL, 8'h00);
   endtask
   task automatic t_edges;
      set_pin(1'b1);
      rd_chk("rising edge", A_CTL, 8'h02);
      wr(A_CTL, 8'h00);
      wr(A_OPT, 8'hBF);
      set_pin(1'b0);
      rd_chk("falling edge", A_CTL, 8'h02);
      wr(A_CTL, 8'h00);
      set_pin(1'b1);
      rd_chk("wrong edge", A_CTL, 8'h00);
      @(posedge hclk);
      port_b <= 4'h5;
      repeat (4) @(posedge hclk);
      rd_chk("port change", A_CTL, 8'h01);
      wr(A_CTL, 8'h00);
      do @(posedge hclk); while (q_phase !== 2'h2);
      port_b <= 4'h0;
      prd <= 1'b1;
      repeat (6) @(posedge hclk);
      prd <= 1'b0;
      rd_chk("lost change", A_CTL, 8'h00);
   endtask
   task automatic t_vector;
      int n;
      wr(A_MSK, 8'h01);
      wr(A_CTL, 8'hA0);
      pulse_ev(8'h08);
      @(posedge hclk);
      #1;
      `CHK("request", 1'b1, irq_request)
      n = 0;
      while (pc_load !== 1'b1 && n < 40)
      begin
         @(posedge hclk);
         #1;
         n++;
      end
      `CHK("latency", 1'b1, (n >= 12 && n <= 20))
      `CHK("vector", 13'h0004, pc_value)
      `CHK("pushed address", core_pc, push_addr)
      rd_chk("entry control", A_CTL, 8'h24);
      `CHK("stack depth", 4'h1, depth)
      `CHK("irq raised", 1'b1, irq)
      rd_chk("status entry", A_STS, 8'h01);
      repeat (2) @(posedge hclk);
      `CHK("irq cleared", 1'b0, irq)
      wr(A_CTL, 8'h20);
      wr(A_MSK, 8'h00);
      @(posedge hclk);
      rfi <= 1'b1;
      @(posedge hclk);
      rfi <= 1'b0;
      rd_chk("return control", A_CTL, 8'hA0);
      `CHK("irq masked", 1'b0, irq)
      rd_chk("status return", A_STS, 8'h04);
      wr(A_CTL, 8'h00);
   endtask
   task automatic t_gating;
      logic [7:0] v [2] = '{8'h20, 8'h80};
      int         s;
      foreach (v[i])
      begin
         wr(A_CTL, v[i]);
         s = n_vec;
         pulse_ev(8'h08);
         repeat (30) @(posedge hclk);
         `CHK("no vector", s, n_vec)
         `CHK("no request", 1'b0, irq_request)
         wr(A_CTL, 8'h00);
      end
      wr(A_CTL, 8'h80);
      @(posedge hclk);
      drop_global <= 1'b1;
      @(posedge hclk);
      drop_global <= 1'b0;
      repeat (10) @(posedge hclk);
      wr(A_CTL, 8'h00);
   endtask
   task automatic t_other_reset;
      wr(A_CTL, 8'h7F);
      @(posedge hclk);
      other_reset <= 1'b1;
      @(posedge hclk);
      other_reset <= 1'b0;
      rd_chk("kept port flag", A_CTL, 8'h01);
      rd_chk("option reset", A_OPT, 8'hFF);
   endtask
   task automatic t_wake;
      int s;
      wr(A_CTL, 8'h10);
      s = n_vec;
      @(posedge hclk);
      sleep <= 1'b1;
      set_pin(1'b0);
      set_pin(1'b1);
      `CHK("wake", 1'b1, wake_request)
      repeat (20) @(posedge hclk);
      `CHK("no vector asleep", s, n_vec)
      rd_chk("status wake", A_STS, 8'h02);
      sleep <= 1'b0;
   endtask
   task end_of_test;
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_values();
      t_flags();
      t_edges();
      t_vector();
      t_gating();
      t_other_reset();
      t_wake();
      end_of_test();
   end
   initial
   begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      end_of_test();
   end
endmodule
bind mil_irq mil_irq_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .global_clear_exec(global_clear_exec), .core_sleep(core_sleep), .q_phase(q_phase),
   .pc_load(pc_load), .pc_value(pc_value), .stack_push(stack_push),
   .nop_insert(nop_insert), .wake_request(wake_request));
`default_nettype wire
